/* File: include/telemetry_regs.svh */
// telemetry readback constants: register offsets, field positions, timing
// assumes a 100 MHz system clock; included by every file that uses one
`ifndef TELEMETRY_REGS_SVH
`define TELEMETRY_REGS_SVH

// ----------------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------------
`define TLM_SLAVE_ADDR      7'h18
`define TLM_READ_PTR_CMD    8'h80
`define TLM_PTR_RESET       8'h02
`define TLM_PTR_STEP        8'h02

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TLM_OFS_SETPOINT    8'h02
`define TLM_OFS_CUR_INST    8'h10
`define TLM_OFS_VOLT_INST   8'h12
`define TLM_OFS_CUR_AVG     8'h18
`define TLM_OFS_VOLT_AVG    8'h1a

// ----------------------------------------------------------------------
// field layout and encoding
// ----------------------------------------------------------------------
`define TLM_VOLT_W          12
`define TLM_CUR_W           8
`define TLM_CUR_PARITY_BIT  15
`define TLM_CUR_FULL_SCALE  8'd192
`define TLM_VQ_FINE_LIMIT   12'd720
`define TLM_VQ_MID_LIMIT    12'd1000
`define TLM_VQ_FINE_STEP    12'd2
`define TLM_VQ_MID_STEP     12'd5
`define TLM_VQ_COARSE_STEP  12'd10
`define TLM_AVG_DEPTH       16
`define TLM_AVG_SHIFT       4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TLM_MEAS_PERIOD_US  100
`define TLM_CLK_MHZ         100
`define TLM_MEAS_CYCLES     (`TLM_MEAS_PERIOD_US * `TLM_CLK_MHZ)
`define TLM_TIMER_W         14

`endif

/* File: include/telemetry_pkg.sv */
// telemetry readback types: bus state machine and the packed module state
// assumes telemetry_regs.svh is on the include path
`include "telemetry_regs.svh"

package telemetry_pkg;

   // ----------------------------------------------------------------------
   // bus slave states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_ACK   = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ  = 3'b100,
      ST_RACK  = 3'b101
   } state_t;

   typedef logic [`TLM_VOLT_W-1:0] volt_t;
   typedef logic [`TLM_CUR_W-1:0]  cur_t;

   // ----------------------------------------------------------------------
   // whole state of the readback block
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                              scl_s1;
      logic                              scl_s2;
      logic                              scl_d;
      logic                              sda_s1;
      logic                              sda_s2;
      logic                              sda_d;
      logic                              sup_s1;
      logic                              sup_s2;
      state_t                            st;
      logic [3:0]                        cnt;
      logic                              rw;
      logic                              cmd_ok;
      logic                              byte_idx;
      logic                              byte_hi;
      logic                              acked;
      logic                              drive;
      logic [7:0]                        rx;
      logic [7:0]                        tx;
      logic [7:0]                        ptr;
      logic [15:0]                       word;
      logic [`TLM_TIMER_W-1:0]           timer;
      logic                              tick;
      volt_t                             vi;
      cur_t                              ci;
      volt_t                             va;
      cur_t                              ca;
      logic [15:0]                       sum_v;
      logic [11:0]                       sum_i;
      logic [3:0]                        idx;
      logic [`TLM_AVG_DEPTH-1:0][11:0]   hv;
      logic [`TLM_AVG_DEPTH-1:0][7:0]    hc;
   } tlm_state_t;

endpackage

/* File: rtl/output_telemetry_readback.sv */
// output voltage and current telemetry with a two-wire readback slave
// assumes samples and switch state come from logic on CLK_SYS; the bus
// pins and the supply comparator are asynchronous and are synchronised
//
// Contract
// - instant voltage readable at 0x12
// - voltage is a 12-bit field
// - steps 20/50/100 mV by voltage range
// - low byte sent first, then high
// - one count equals 10 mV
// - instant relative current readable at 0x10
// - count 192 means full threshold
// - odd parity bit in current high byte; code sets even parity (bit 15 is the XOR of the count)
// - 16-sample rolling averages, current and voltage
// - averages cleared while output switch open
// - averages share instant encoding
// - all measurements refresh every 100 us
// - silent on bus while supply low
// - setpoint readable at 0x02, same order
`timescale 1ns/100ps
// constants are pulled in here too, so this file stands in its own unit
`include "telemetry_regs.svh"

module output_telemetry_readback
   import telemetry_pkg::*;
#(
   parameter int MEAS_CYCLES = `TLM_MEAS_CYCLES
) (
   // clock and reset
   input  wire logic                 CLK_SYS,
   input  wire logic                 RESET,
   // measurement front end
   input  wire telemetry_pkg::volt_t VOLT_SAMPLE,
   input  wire telemetry_pkg::cur_t  CURRENT_SAMPLE,
   input  wire logic [15:0]          SETPOINT,
   input  wire logic                 SWITCH_CLOSED,
   // supply monitor, asynchronous
   input  wire logic                 SUPPLY_OK,
   // two-wire bus pins
   input  wire logic                 SCL_IN,
   input  wire logic                 SDA_IN,
   output logic                      SDA_OUT,
   output logic                      SDA_OE
);
   import telemetry_pkg::*;

   // ----------------------------------------------------------------------
   // state and decoded bus events
   // ----------------------------------------------------------------------
   tlm_state_t s;      // registered state
   tlm_state_t n;      // next state
   logic       rise;   // scl rising
   logic       fall;   // scl falling
   logic       start;  // start condition
   logic       stop;   // stop condition

   localparam logic [`TLM_TIMER_W-1:0] TIMER_LAST =
      `TLM_TIMER_W'(MEAS_CYCLES - 1);

   // round a 10 mV count down to the step of its range
   function automatic volt_t vquant(input volt_t v);
      volt_t r;
      r = v;
      if (v < `TLM_VQ_FINE_LIMIT) begin
         r = v - (v % `TLM_VQ_FINE_STEP);
      end else if (v < `TLM_VQ_MID_LIMIT) begin
         r = v - (v % `TLM_VQ_MID_STEP);
      end else begin
         r = v - (v % `TLM_VQ_COARSE_STEP);
      end
      return r;
   endfunction

   // current word: count in low byte, parity flag on top of high byte
   function automatic logic [15:0] cur_word(input cur_t c);
      logic [15:0] w;
      w = {8'h00, c};
      w[`TLM_CUR_PARITY_BIT] = ^c;
      return w;
   endfunction

   // register map; unmapped offsets read zero
   function automatic logic [15:0] word_at(input logic [7:0] a,
                                           input tlm_state_t t);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         `TLM_OFS_SETPOINT:  w = SETPOINT;
         `TLM_OFS_CUR_INST:  w = cur_word(t.ci);
         `TLM_OFS_VOLT_INST: w = {4'h0, t.vi};
         `TLM_OFS_CUR_AVG:   w = cur_word(t.ca);
         `TLM_OFS_VOLT_AVG:  w = {4'h0, t.va};
         default:            w = 16'h0000;
      endcase
      return w;
   endfunction

   // ----------------------------------------------------------------------
   // bus edge decode, only from second synchroniser stage onward
   // ----------------------------------------------------------------------
   always_comb begin
      rise  = s.scl_s2 & ~s.scl_d;
      fall  = ~s.scl_s2 & s.scl_d;
      start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
      stop  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      n = s;
      // synchronisers: first stage feeds only the second
      n.scl_s1 = SCL_IN;
      n.scl_s2 = s.scl_s1;
      n.scl_d  = s.scl_s2;
      n.sda_s1 = SDA_IN;
      n.sda_s2 = s.sda_s1;
      n.sda_d  = s.sda_s2;
      n.sup_s1 = SUPPLY_OK;
      n.sup_s2 = s.sup_s1;

      // measurement interval timer, free running
      n.tick = 1'b0;
      if (s.timer == TIMER_LAST) begin
         n.timer = '0;
         n.tick  = 1'b1;
      end else begin
         n.timer = s.timer + 1'b1;
      end

      // refresh instants and rolling sums once per interval
      if (s.tick) begin
         n.vi         = vquant(VOLT_SAMPLE);
         n.ci         = CURRENT_SAMPLE;
         // sum stays exact: add newest, drop the one sixteen back
         n.sum_v      = s.sum_v + {4'h0, VOLT_SAMPLE}
                        - {4'h0, s.hv[s.idx]};
         n.sum_i      = s.sum_i + {4'h0, CURRENT_SAMPLE}
                        - {4'h0, s.hc[s.idx]};
         n.hv[s.idx]  = VOLT_SAMPLE;
         n.hc[s.idx]  = CURRENT_SAMPLE;
         n.idx        = s.idx + 1'b1;
         // unfilled slots count as zero, so averages ramp up
         n.va = vquant(n.sum_v[15:`TLM_AVG_SHIFT]);
         n.ca = n.sum_i[11:`TLM_AVG_SHIFT];
      end

      // open switch wipes the history; restarts from fresh samples
      if (!SWITCH_CLOSED) begin
         n.sum_v = '0;
         n.sum_i = '0;
         n.hv    = '0;
         n.hc    = '0;
         n.idx   = '0;
         n.va    = '0;
         n.ca    = '0;
      end

      // bus slave
      if (!s.sup_s2) begin
         // low supply: drop any transfer and release the line
         n.st    = ST_IDLE;
         n.drive = 1'b0;
      end else if (start) begin
         n.st    = ST_ADDR;
         n.cnt   = 4'h0;
         n.drive = 1'b0;
      end else if (stop) begin
         n.st    = ST_IDLE;
         n.drive = 1'b0;
      end else begin
         case (s.st)
            ST_IDLE: begin
               n.drive = 1'b0;
            end
            ST_ADDR: begin
               if (rise) begin
                  n.rx  = {s.rx[6:0], s.sda_s2};
                  n.cnt = s.cnt + 1'b1;
               end else if (fall && s.cnt == 4'h8) begin
                  if (s.rx[7:1] == `TLM_SLAVE_ADDR) begin
                     n.st       = ST_ACK;
                     n.drive    = 1'b1;
                     n.rw       = s.rx[0];
                     n.byte_idx = 1'b0;
                     n.byte_hi  = 1'b0;
                     // freeze both bytes before the first goes out
                     n.word     = word_at(s.ptr, s);
                  end else begin
                     n.st = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (fall) begin
                  n.cnt = 4'h0;
                  if (s.rw) begin
                     n.st    = ST_READ;
                     n.tx    = {s.word[6:0], 1'b0};
                     n.drive = ~s.word[7];
                  end else begin
                     n.st    = ST_WRITE;
                     n.drive = 1'b0;
                  end
               end
            end
            ST_WRITE: begin
               if (rise) begin
                  n.rx  = {s.rx[6:0], s.sda_s2};
                  n.cnt = s.cnt + 1'b1;
               end else if (fall && s.cnt == 4'h8) begin
                  n.st       = ST_ACK;
                  n.drive    = 1'b1;
                  n.byte_idx = 1'b1;
                  // first byte is the command, second the pointer
                  if (!s.byte_idx) begin
                     n.cmd_ok = (s.rx == `TLM_READ_PTR_CMD);
                  end else if (s.cmd_ok) begin
                     n.ptr    = s.rx;
                     n.cmd_ok = 1'b0;
                  end
               end
            end
            ST_READ: begin
               if (rise) begin
                  n.cnt = s.cnt + 1'b1;
               end else if (fall) begin
                  if (s.cnt == 4'h8) begin
                     n.st    = ST_RACK;
                     n.drive = 1'b0;
                  end else begin
                     n.drive = ~s.tx[7];
                     n.tx    = {s.tx[6:0], 1'b0};
                  end
               end
            end
            ST_RACK: begin
               if (rise) begin
                  n.acked = ~s.sda_s2;
               end else if (fall) begin
                  if (!s.acked) begin
                     // master nack ends the read
                     n.st = ST_IDLE;
                  end else begin
                     n.st  = ST_READ;
                     n.cnt = 4'h0;
                     if (!s.byte_hi) begin
                        n.byte_hi = 1'b1;
                        n.tx      = {s.word[14:8], 1'b0};
                        n.drive   = ~s.word[15];
                     end else begin
                        // next word in the polling sequence
                        n.byte_hi = 1'b0;
                        n.ptr     = s.ptr + `TLM_PTR_STEP;
                        n.word    = word_at(n.ptr, s);
                        n.tx      = {n.word[6:0], 1'b0};
                        n.drive   = ~n.word[7];
                     end
                  end
               end
            end
            default: begin
               n.st    = ST_IDLE;
               n.drive = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         s     <= '0;
         s.ptr <= `TLM_PTR_RESET;
         // bus synchronisers start at the idle line level, so the first
         // edges after reset never decode a clock edge that did not happen
         s.scl_s1 <= 1'b1;
         s.scl_s2 <= 1'b1;
         s.scl_d  <= 1'b1;
         s.sda_s1 <= 1'b1;
         s.sda_s2 <= 1'b1;
         s.sda_d  <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // open-drain data pin: only ever pulls low
   assign SDA_OUT = 1'b0;
   assign SDA_OE  = s.drive;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   AST_VOLT_REFRESH: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      s.tick |=> s.vi == vquant($past(VOLT_SAMPLE)))
      else $error("voltage instant not refreshed on tick");

   // the latched voltage word must carry nothing above the 12-bit count
   AST_VOLT_WIDTH: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s.st == ST_READ && s.ptr == `TLM_OFS_VOLT_INST)
      |-> s.word[15:12] == 4'h0)
      else $error("voltage word carries bits above the count");

   AST_VOLT_STEP: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s.vi >= `TLM_VQ_MID_LIMIT)
      |-> (s.vi % `TLM_VQ_COARSE_STEP) == 12'h000)
      else $error("coarse voltage step broken");

   AST_CUR_PARITY: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      s.tick |=> cur_word(s.ci) == {^$past(CURRENT_SAMPLE), 7'h00,
                                    $past(CURRENT_SAMPLE)})
      else $error("current word parity or count wrong");

   AST_AVG_CLEAR: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      !SWITCH_CLOSED |=> s.va == '0 && s.ca == '0 && s.sum_v == '0)
      else $error("averages not cleared with switch open");

   AST_AVG_FIRST: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s.tick && SWITCH_CLOSED && s.sum_i == '0 && s.hc[s.idx] == '0)
      |=> s.ca == 8'($past(CURRENT_SAMPLE) >> `TLM_AVG_SHIFT))
      else $error("current average not sum over sixteen");

   AST_SUPPLY_SILENT: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      !SUPPLY_OK [*3] |=> !SDA_OE && s.st == ST_IDLE)
      else $error("slave active with supply low");

   AST_WORD_LATCH: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s.st == ST_READ) |=> $stable(s.word))
      else $error("word changed during a byte");

   AST_HIGH_AFTER_LOW: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s.sup_s2 && !start && !stop && s.st == ST_RACK && fall && s.acked
       && !s.byte_hi) |=> s.byte_hi && SDA_OE == ~s.word[15])
      else $error("high byte not sent after low byte");

   AST_ZERO_AFTER_RESET: assert property (@(posedge CLK_SYS)
      $fell(RESET) |-> s.vi == '0 && s.ci == '0 && s.va == '0
                       && s.ca == '0)
      else $error("measurements not zero after reset");

endmodule // output_telemetry_readback

/* File: testbench/i2c_master_model.sv */
// two-wire bus master that reads the telemetry block
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
`include "telemetry_regs.svh"

module i2c_master_model (
   // clock
   input  wire logic CLK_SYS,
   // resolved data wire
   input  wire logic SDA_LINE,
   // bus pins driven by the master
   output logic      SCL,
   output logic      SDA_LOW
);
   // ----------------------------------------------------------------
   // bit timing
   // ----------------------------------------------------------------
   // asymmetric clock, long low phase, so the bench stays short
   localparam int LOW_CYC  = 16;
   localparam int HIGH_CYC = 10;

   // idle bus: clock stands high and data is released
   initial begin
      SCL     = 1'b1;
      SDA_LOW = 1'b0;
   end

   // all changes land on the falling edge of the system clock
   task automatic wait_n(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask

   // start or repeated start: data falls while the clock is high
   task automatic bus_start;
      SDA_LOW = 1'b0;
      wait_n(LOW_CYC / 2);
      SCL = 1'b1;
      wait_n(HIGH_CYC);
      SDA_LOW = 1'b1;
      wait_n(HIGH_CYC);
      SCL = 1'b0;
      wait_n(LOW_CYC / 2);
   endtask

   // stop: data rises while the clock is high
   task automatic bus_stop;
      SDA_LOW = 1'b1;
      wait_n(LOW_CYC / 2);
      SCL = 1'b1;
      wait_n(HIGH_CYC);
      SDA_LOW = 1'b0;
      wait_n(HIGH_CYC);
   endtask

   // one bit: data set mid-low, sampled mid-high
   task automatic bit_xfer(input logic b, output logic r);
      SDA_LOW = !b;
      wait_n(LOW_CYC / 2);
      SCL = 1'b1;
      wait_n(HIGH_CYC / 2);
      r = SDA_LINE;
      wait_n(HIGH_CYC / 2);
      SCL = 1'b0;
      wait_n(LOW_CYC / 2);
   endtask

   // eight bits msb first, then the acknowledge bit
   task automatic byte_xfer(input logic [7:0] d, input logic ack_out,
                            output logic [7:0] r, output logic ack_in);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r[i]);
      end
      bit_xfer(ack_out, ack_in);
   endtask

   // address only, to probe whether the slave answers
   task automatic probe(input logic [6:0] addr, output logic nack);
      logic [7:0] r;
      bus_start();
      byte_xfer({addr, 1'b0}, 1'b1, r, nack);
      bus_stop();
   endtask

   // pointer command then register address
   task automatic set_pointer(input logic [6:0] addr, input logic [7:0] p,
                              output logic ok);
      logic [7:0] r;
      logic [2:0] n;
      bus_start();
      byte_xfer({addr, 1'b0}, 1'b1, r, n[0]);
      byte_xfer(`TLM_READ_PTR_CMD, 1'b1, r, n[1]);
      byte_xfer(p, 1'b1, r, n[2]);
      bus_stop();
      ok = (n == 3'b000);
   endtask

   // read nb bytes; low byte first, words packed from bit 0 up
   task automatic read_bytes(input logic [6:0] addr, input int nb,
                             output logic [31:0] w, output logic ok);
      logic [7:0] r;
      logic       a;
      w = 32'h0;
      bus_start();
      byte_xfer({addr, 1'b1}, 1'b1, r, a);
      ok = !a;
      for (int k = 0; k < nb; k++) begin
         byte_xfer(8'hff, k == nb - 1, r, a);
         w[k*8 +: 8] = r;
      end
      bus_stop();
   endtask
endmodule // i2c_master_model

/* File: testbench/testbench.sv */
// self-checking bench for the output telemetry readback block
// assumes the master model sits on the bus; one 100 MHz clock
`timescale 1ns/100ps
`include "telemetry_regs.svh"
`define TB_CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
   n_errors++; $display("Error at %0t: got %h expected %h", $time, got, \
   exp); end end

module testbench;
   import telemetry_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int MEAS  = 3200;     // short interval keeps the run brief
   localparam int LIMIT = 98000;    // cycle ceiling for the whole run
   localparam logic [6:0] ADDR = `TLM_SLAVE_ADDR;
   typedef struct {
      volt_t v; cur_t c; logic [15:0] ev; logic [15:0] ec;
   } row_t;
   logic        CLK_SYS, RESET, SWITCH_CLOSED, SUPPLY_OK;
   volt_t       VOLT_SAMPLE;
   cur_t        CURRENT_SAMPLE;
   logic [15:0] SETPOINT;
   logic        scl, sda_low, sda_line, SDA_OUT, SDA_OE, ok, nack;
   logic [31:0] w;
   int          n_errors, n_compared, cycles;
   // ordinary cases: quantisation edges and parity of the current word
   row_t rows [5] = '{
      '{12'd719,  8'h40, 16'h02ce, 16'h8040},
      '{12'd720,  8'hc0, 16'h02d0, 16'h00c0},
      '{12'd999,  8'h07, 16'h03e3, 16'h8007},
      '{12'd1000, 8'h00, 16'h03e8, 16'h0000},
      '{12'd2409, 8'hff, 16'h0960, 16'h00ff}};

   // open-drain wire with pull-up: low if either party pulls
   assign sda_line = !((SDA_OE && !SDA_OUT) || sda_low);

   output_telemetry_readback #(.MEAS_CYCLES(MEAS)) DUT (
      .CLK_SYS(CLK_SYS), .RESET(RESET), .VOLT_SAMPLE(VOLT_SAMPLE),
      .CURRENT_SAMPLE(CURRENT_SAMPLE), .SETPOINT(SETPOINT),
      .SWITCH_CLOSED(SWITCH_CLOSED), .SUPPLY_OK(SUPPLY_OK),
      .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT),
      .SDA_OE(SDA_OE));

   i2c_master_model m (
      .CLK_SYS(CLK_SYS), .SDA_LINE(sda_line), .SCL(scl),
      .SDA_LOW(sda_low));

   // ----------------------------------------------------------------
   // clock, timeout and verdict
   // ----------------------------------------------------------------
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   // a hang counts as a mismatch and ends the run
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask

   // point at a register and fetch two consecutive words
   task automatic read_two(input logic [7:0] p);
      m.set_pointer(ADDR, p, ok);
      `TB_CHECK(ok, 1'b1)
      m.read_bytes(ADDR, 4, w, ok);
      `TB_CHECK(ok, 1'b1)
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      RESET = 1'b1;
      VOLT_SAMPLE = 12'd1200;
      CURRENT_SAMPLE = 8'h33;
      SETPOINT = 16'h1a2b;
      SWITCH_CLOSED = 1'b1;
      SUPPLY_OK = 1'b1;
      wait_cyc(4);
      RESET = 1'b0;
      wait_cyc(4);
      // pointer starts at the setpoint; value comes low byte first
      m.read_bytes(ADDR, 2, w, ok);
      `TB_CHECK(w[15:0], 16'h1a2b)
      // before the first interval ends both instants still read zero
      read_two(`TLM_OFS_CUR_INST);
      `TB_CHECK(w, 32'h0)
      // table of samples: one interval, then poll both instants
      foreach (rows[i]) begin
         VOLT_SAMPLE = rows[i].v;
         CURRENT_SAMPLE = rows[i].c;
         wait_cyc(MEAS + 10);
         read_two(`TLM_OFS_CUR_INST);
         `TB_CHECK(w[15:0], rows[i].ec)
         `TB_CHECK(w[31:16], rows[i].ev)
      end
      // fresh history after the switch recloses, then seventeen intervals of samples
      SWITCH_CLOSED = 1'b0;
      VOLT_SAMPLE = 12'd1003;
      CURRENT_SAMPLE = 8'h41;
      wait_cyc(10);
      SWITCH_CLOSED = 1'b1;
      wait_cyc(17 * MEAS);
      read_two(`TLM_OFS_CUR_AVG);
      `TB_CHECK(w[15:0], 16'h0041)
      `TB_CHECK(w[31:16], 16'h03e8)
      // opening the switch clears both averages
      SWITCH_CLOSED = 1'b0;
      wait_cyc(10);
      read_two(`TLM_OFS_CUR_AVG);
      `TB_CHECK(w, 32'h0)
      SWITCH_CLOSED = 1'b1;
      // unmapped pointer reads zero
      read_two(8'h40);
      `TB_CHECK(w, 32'h0)
      // foreign address gets no acknowledge
      m.probe(ADDR + 7'd1, nack);
      `TB_CHECK(nack, 1'b1)
      // low controller supply silences the slave, recovery restores it
      SUPPLY_OK = 1'b0;
      wait_cyc(10);
      m.probe(ADDR, nack);
      `TB_CHECK(nack, 1'b1)
      SUPPLY_OK = 1'b1;
      wait_cyc(10);
      m.probe(ADDR, nack);
      `TB_CHECK(nack, 1'b0)
      // mid-run reset: line released, pointer home, both instants zero
      RESET = 1'b1;
      wait_cyc(4);
      `TB_CHECK(SDA_OE, 1'b0)
      `TB_CHECK(SDA_OUT, 1'b0)
      RESET = 1'b0;
      wait_cyc(4);
      m.read_bytes(ADDR, 2, w, ok);
      `TB_CHECK(w[15:0], 16'h1a2b)
      read_two(`TLM_OFS_CUR_INST);
      `TB_CHECK(w, 32'h0)
      report_and_stop();
   end
endmodule // testbench
